// [hdl/pin_edge_detect.sv]
// two-stage synchroniser and edge detector for the timer input pin
// assumed: pin is asynchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module pin_edge_detect (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // pin
    input wire logic pin_i,
    // level and edges
    output logic level_o,
    output logic rise_o,
    output logic fall_o
);
    logic meta;
    logic sync;
    logic prev;

    // first stage is read only by the second
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin_i;
            sync <= meta;
            prev <= sync;
        end
    end

    assign level_o = sync;
    assign rise_o = sync & ~prev;
    assign fall_o = ~sync & prev;
endmodule : pin_edge_detect
`default_nettype wire

// [hdl/tmr_chan.sv]
// one timer channel: mode register, start/stop triggers, capture, irq flag and mask
// assumed: prescaler tick inputs are one-cycle pulses on clk_i; master irq from same clock
`timescale 1ns/1ps
`default_nettype none
`include "tmr_chan_params.svh"

// Contract
// [RQ1] clock select field picks prescaled tick
// [RQ2] count source: master tick or pin edge
// [RQ3] trigger select 000: software start only
// [RQ4] trigger select 001: valid edge starts/captures
// [RQ5] trigger select 010: both edges, pulse width
// [RQ6] trigger select 100: master channel irq triggers
// [RQ7] edge select: fall, rise, both low/high
// [RQ8] lowest mode bit: irq at count start
// [RQ9] one-count: lowest bit lets retrigger restart
// [RQ10] capture one-count: no start irq, no retrigger
// [RQ11] flag set on irq; software clears first
// [RQ12] mask bit one blocks irq servicing
// [RQ13] software writes only channel start bit
// [RQ14] start bit one sets enable status
// [RQ15] stop bit one clears enable status
// [RQ16] capture trigger copies count, raises irq
module tmr_chan
    import tmr_chan_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [15:0] rdata_o,
    // prescaler ticks and slave trigger
    input wire logic [3:0] presc_tick_i,
    input wire logic master_irq_i,
    // pin
    input wire logic timer_input_pin_i,
    // outputs
    output logic chan_irq_o,
    output logic irq_o,
    output logic chan_enable_status_o
);
    import tmr_chan_pkg::*;

    logic [15:0] mode;
    logic [7:0] irq_flags;
    logic [7:0] irq_mask;
    logic [WIDTH-1:0] count;
    logic [WIDTH-1:0] period;
    logic [WIDTH-1:0] data;
    logic [2:0] ev_status;
    logic [2:0] ev_enable;
    logic enable;
    run_state_t state;
    logic pin_level;
    logic pin_rise;
    logic pin_fall;

    pin_edge_detect pin_edge_detect_i (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .pin_i(timer_input_pin_i),
        .level_o(pin_level),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    // field views
    logic [1:0] clk_sel;
    logic count_clock_source;
    logic [2:0] trig_sel;
    edge_sel_t edge_sel;
    op_mode_t op_mode;
    assign clk_sel = mode[15:14];
    assign count_clock_source = mode[12];
    assign trig_sel = mode[10:8];
    assign edge_sel = edge_sel_t'(mode[7:6]);
    assign op_mode = op_mode_t'(mode[3:0]);

    function automatic logic sel_edge(input edge_sel_t s, input logic r, input logic f);
        case (s)
            EDGE_FALL: sel_edge = f;
            EDGE_RISE: sel_edge = r;
            default: sel_edge = r | f;
        endcase
    endfunction : sel_edge

    // master tick: note 01 and 10 are swapped against the tick index
    logic mck_tick;
    always_comb begin
        case (clk_sel)
            2'b00: mck_tick = presc_tick_i[0]; // [RQ1]
            2'b01: mck_tick = presc_tick_i[2]; // [RQ1]
            2'b10: mck_tick = presc_tick_i[1]; // [RQ1]
            default: mck_tick = presc_tick_i[3]; // [RQ1]
        endcase
    end

    logic valid_edge;
    assign valid_edge = sel_edge(edge_sel, pin_rise, pin_fall); // [RQ7]
    logic count_tick;
    assign count_tick = count_clock_source ? valid_edge : mck_tick; // [RQ2]

    // for both-edge measurement the starting edge is the one opening the measured level
    logic start_edge;
    logic end_edge;
    always_comb begin
        start_edge = 1'b0;
        end_edge = 1'b0;
        case (trig_sel)
            3'b001: begin
                start_edge = valid_edge; // [RQ4]
                end_edge = valid_edge; // [RQ4]
            end
            3'b010: begin
                start_edge = (edge_sel == EDGE_BOTH_HIGH) ? pin_rise : pin_fall; // [RQ5] [RQ7]
                end_edge = pin_rise | pin_fall; // [RQ5]
            end
            3'b100: begin
                start_edge = master_irq_i; // [RQ6]
                end_edge = master_irq_i; // [RQ6]
            end
            default: start_edge = 1'b0; // [RQ3]
        endcase
    end
    logic sw_start;
    logic sw_stop;
    assign sw_start = wr_i && addr_i == `OFS_START && wdata_i[0]; // [RQ14] [RQ13]
    assign sw_stop = wr_i && addr_i == `OFS_STOP && wdata_i[0]; // [RQ15]

    logic is_capture;
    logic is_onecount;
    logic start_irq;
    logic retrig_ok;
    assign is_capture = op_mode == MD_CAPTURE || op_mode == MD_CAPTURE_SI || op_mode == MD_CAP_ONE;
    assign is_onecount = op_mode == MD_ONECOUNT || op_mode == MD_ONECOUNT_RS || op_mode == MD_CAP_ONE;
    // event counter and one-count variants never fire at start
    assign start_irq = (op_mode == MD_INTERVAL_SI) || (op_mode == MD_CAPTURE_SI); // [RQ8] [RQ10]
    assign retrig_ok = op_mode == MD_ONECOUNT_RS; // [RQ9] [RQ10]
    logic hw_start;
    assign hw_start = enable && trig_sel != 3'b000 && start_edge;
    // channel event pulses
    logic ev_cap;
    logic ev_zero;
    logic ev_begin;
    logic next_chan_irq;
    always_comb begin
        ev_cap = 1'b0;
        ev_zero = 1'b0;
        ev_begin = 1'b0;
        case (state)
            ST_IDLE: ev_begin = sw_start && trig_sel == 3'b000 && start_irq; // [RQ8]
            ST_WAIT: ev_begin = hw_start && start_irq; // [RQ8]
            ST_RUN: begin
                if (is_capture && end_edge)
                    ev_cap = 1'b1; // [RQ16]
                if (!is_capture && count_tick && count == '0)
                    ev_zero = 1'b1;
            end
            default: ev_begin = 1'b0;
        endcase
        next_chan_irq = ev_cap | ev_zero | ev_begin;
    end

    // run state: wait for trigger, count, stop
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            state <= ST_IDLE;
        end else if (sw_stop) begin
            state <= ST_IDLE; // [RQ15]
        end else begin
            case (state)
                ST_IDLE: if (sw_start) state <= (trig_sel == 3'b000) ? ST_RUN : ST_WAIT;
                ST_WAIT: if (hw_start) state <= ST_RUN;
                ST_RUN: if (is_onecount && (ev_zero || ev_cap) && !(hw_start && retrig_ok)) state <= ST_WAIT; // [RQ10]
                default: state <= ST_IDLE;
            endcase
        end
    end
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            enable <= 1'b0;
        end else if (sw_start) begin
            enable <= 1'b1; // [RQ14]
        end else if (sw_stop) begin
            enable <= 1'b0; // [RQ15]
        end
    end

    // counter: capture counts up, others reload from period and count down
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            count <= '0;
        end else if ((state == ST_IDLE && sw_start) || (state == ST_WAIT && hw_start)) begin
            count <= is_capture ? '0 : period;
        end else if (state == ST_RUN) begin
            if (is_onecount && hw_start && retrig_ok) begin
                count <= period; // [RQ9]
            end else if (ev_cap) begin
                count <= '0;
            end else if (count_tick) begin
                if (is_capture)
                    count <= count + 1'b1;
                else
                    count <= (count == '0) ? period : count - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            data <= '0;
        end else if (ev_cap) begin
            data <= count; // [RQ16]
        end
    end

    // registers written by software
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            mode <= `MODE_RESET;
            irq_mask <= `MASK_RESET;
            period <= '0;
            ev_enable <= '0;
        end else if (wr_i) begin
            case (addr_i)
                `OFS_MODE: mode <= wdata_i & `MODE_WMASK;
                `OFS_IRQ_MASK: irq_mask <= wdata_i[7:0]; // [RQ12]
                `OFS_PERIOD: period <= wdata_i[WIDTH-1:0];
                `OFS_EV_ENABLE: ev_enable <= wdata_i[2:0];
                default: ;
            endcase
        end
    end

    // set wins over software clear
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            irq_flags <= '0;
        end else begin
            if (wr_i && addr_i == `OFS_IRQ_FLAGS)
                irq_flags <= wdata_i[7:0];
            if (next_chan_irq)
                irq_flags[`FLAG_BIT] <= 1'b1; // [RQ11]
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            ev_status <= '0;
        end else begin
            ev_status <= (wr_i && addr_i == `OFS_EV_CLEAR) ? (ev_status & ~wdata_i[2:0]) : ev_status;
            if (ev_cap) ev_status[`EV_CAPTURE] <= 1'b1;
            if (ev_zero) ev_status[`EV_UNDERFLOW] <= 1'b1;
            if (ev_begin) ev_status[`EV_START] <= 1'b1;
        end
    end

    // outputs straight from flops
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            chan_irq_o <= 1'b0;
            irq_o <= 1'b0;
            chan_enable_status_o <= 1'b0;
        end else begin
            chan_irq_o <= next_chan_irq;
            // flag pends even while masked; mask only gates servicing
            irq_o <= (irq_flags[`FLAG_BIT] & ~irq_mask[`FLAG_BIT]) | (|(ev_status & ev_enable)); // [RQ12]
            chan_enable_status_o <= enable;
        end
    end

    // read data one cycle later
    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else if (rd_i) begin
            case (addr_i)
                `OFS_MODE: rdata_o <= mode;
                `OFS_IRQ_FLAGS: rdata_o <= {8'h00, irq_flags};
                `OFS_IRQ_MASK: rdata_o <= {8'h00, irq_mask};
                `OFS_STATUS: rdata_o <= {12'h000, pin_level, 1'b0, state == ST_RUN, enable};
                `OFS_DATA: rdata_o <= 16'(data);
                `OFS_COUNT: rdata_o <= 16'(count);
                `OFS_EV_STATUS: rdata_o <= {13'h0000, ev_status};
                `OFS_EV_ENABLE: rdata_o <= {13'h0000, ev_enable};
                `OFS_PERIOD: rdata_o <= 16'(period);
                default: rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    property p_start_sets_enable;
        @(posedge clk_i) disable iff (!rst_b_i) sw_start |=> ##1 chan_enable_status_o;
    endproperty
    a_start_sets_enable: assert property (p_start_sets_enable) else $error("start did not enable"); // [RQ14]

    property p_stop_clears_enable;
        @(posedge clk_i) disable iff (!rst_b_i) (sw_stop && !sw_start) |=> ##1 !chan_enable_status_o;
    endproperty
    a_stop_clears_enable: assert property (p_stop_clears_enable) else $error("stop did not disable"); // [RQ15]

    property p_capture_copies;
        @(posedge clk_i) disable iff (!rst_b_i) ev_cap |=> data == $past(count);
    endproperty
    a_capture_copies: assert property (p_capture_copies) else $error("capture lost count"); // [RQ16]

    property p_flag_sets;
        @(posedge clk_i) disable iff (!rst_b_i) next_chan_irq |=> irq_flags[`FLAG_BIT];
    endproperty
    a_flag_sets: assert property (p_flag_sets) else $error("irq flag not set"); // [RQ11]

    property p_mask_blocks;
        @(posedge clk_i) disable iff (!rst_b_i) (irq_mask[`FLAG_BIT] && ev_enable == '0) |=> !irq_o;
    endproperty
    a_mask_blocks: assert property (p_mask_blocks) else $error("masked irq serviced"); // [RQ12]

    property p_sw_only;
        @(posedge clk_i) disable iff (!rst_b_i) (state == ST_WAIT && trig_sel == 3'b000) |=> state != ST_RUN;
    endproperty
    a_sw_only: assert property (p_sw_only) else $error("hw trigger in sw mode"); // [RQ3]

    property p_no_start_irq;
        @(posedge clk_i) disable iff (!rst_b_i) (op_mode == MD_CAP_ONE || op_mode == MD_EVENT) |-> !ev_begin;
    endproperty
    a_no_start_irq: assert property (p_no_start_irq) else $error("start irq in wrong mode"); // [RQ10]

    property p_clk_sel;
        @(posedge clk_i) disable iff (!rst_b_i) mck_tick == presc_tick_i[{clk_sel[0], clk_sel[1]}];
    endproperty
    a_clk_sel: assert property (p_clk_sel) else $error("wrong prescaler tick"); // [RQ1]
endmodule : tmr_chan
`default_nettype wire

// [hdl/tmr_chan_params.svh]
// register offsets, field positions, reset values and timing counts for one timer channel
// assumed: included by the channel package users; defines only
`ifndef TMR_CHAN_PARAMS_SVH
`define TMR_CHAN_PARAMS_SVH
`define OFS_MODE 4'h0
`define OFS_IRQ_FLAGS 4'h1
`define OFS_IRQ_MASK 4'h2
`define OFS_START 4'h3
`define OFS_STOP 4'h4
`define OFS_STATUS 4'h5
`define OFS_DATA 4'h6
`define OFS_COUNT 4'h7
`define OFS_EV_STATUS 4'h8
`define OFS_EV_CLEAR 4'h9
`define OFS_EV_ENABLE 4'ha
`define OFS_PERIOD 4'hb
`define MODE_RESET 16'h0184
`define MODE_WMASK 16'hd7cf
`define FLAG_BIT 4
`define MASK_RESET 8'hff
`define EV_CAPTURE 0
`define EV_UNDERFLOW 1
`define EV_START 2
`define SYNC_STAGES 2
`endif

// [hdl/tmr_chan_pkg.sv]
// types shared by the timer channel files
// assumed: compiled before the channel modules
package tmr_chan_pkg;
    typedef enum logic [1:0] {
        EDGE_FALL = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_BOTH_LOW = 2'b10,
        EDGE_BOTH_HIGH = 2'b11
    } edge_sel_t;
    typedef enum logic [3:0] {
        MD_INTERVAL = 4'b0000,
        MD_INTERVAL_SI = 4'b0001,
        MD_CAPTURE = 4'b0100,
        MD_CAPTURE_SI = 4'b0101,
        MD_EVENT = 4'b0110,
        MD_ONECOUNT = 4'b1000,
        MD_ONECOUNT_RS = 4'b1001,
        MD_CAP_ONE = 4'b1100
    } op_mode_t;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_RUN = 2'b10
    } run_state_t;
endpackage : tmr_chan_pkg

// [tb/pulse_source.sv]
// model of the external pulse source on the timer input pin
// assumes: the caller allows for the pin synchroniser after each change
`timescale 1ns/1ps
`default_nettype none
module pulse_source (
    // pin
    output logic pin_o
);
    initial begin
        pin_o = 1'b0;
    end
    // changes land between clock edges, as an unrelated source would
    task automatic set_level(input logic lvl);
        #3.3 pin_o = lvl;
    endtask : set_level
endmodule : pulse_source
`default_nettype wire

// [tb/tmr_chan_tb.sv]
// self-checking bench for one timer channel
// assumes: pulse_source drives the pin; bench drives ticks and the master irq
`timescale 1ns/1ps
`default_nettype none
`include "tmr_chan_params.svh"
module tmr_chan_tb;
    import tmr_chan_pkg::*;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic [3:0] tick = 4'h0;
    logic mirq = 1'b0;
    wire logic pin;
    logic irq;
    logic cirq;
    logic en;
    logic [15:0] d;
    logic [15:0] c0;
    int n_errors = 0;
    int checks_done = 0;
    int n_pulses = 0;
    int idx[4] = '{0, 2, 1, 3};
    logic [15:0] mds[6] = '{16'h0004, 16'h0005, 16'h0000, 16'h0001, 16'h0006, 16'h000c};
    logic [15:0] fl[6] = '{16'h0000, 16'h0010, 16'h0000, 16'h0010, 16'h0000, 16'h0000};

    initial begin
        forever #2.5 clk_i = ~clk_i;
    end

    pulse_source pulse_source_i (.pin_o(pin));
    tmr_chan tmr_chan_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .presc_tick_i(tick), .master_irq_i(mirq), .timer_input_pin_i(pin),
        .chan_irq_o(cirq), .irq_o(irq), .chan_enable_status_o(en));

    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wr_reg

    // data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 v = rdata;
    endtask : rd_reg

    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : settle

    // synchroniser plus detect takes a few cycles
    task automatic pin_to(input logic v);
        pulse_source_i.set_level(v);
        settle(8);
    endtask : pin_to

    task automatic pulse(input logic [3:0] t);
        @(posedge clk_i);
        tick <= t;
        @(posedge clk_i);
        tick <= 4'h0;
    endtask : pulse

    task automatic mpulse();
        @(posedge clk_i);
        mirq <= 1'b1;
        @(posedge clk_i);
        mirq <= 1'b0;
        settle(3);
    endtask : mpulse

    // sampled mid-cycle so the one-cycle event pulse is seen exactly once
    always @(negedge clk_i) begin
        if (cirq)
            n_pulses++;
    end

    task automatic prep(input logic [15:0] m);
        wr_reg(`OFS_STOP, 16'h0001);
        wr_reg(`OFS_EV_CLEAR, 16'h0007);
        wr_reg(`OFS_IRQ_FLAGS, 16'h0000);
        wr_reg(`OFS_MODE, m);
        wr_reg(`OFS_START, 16'h0001);
        settle(3);
    endtask : prep

    task automatic chk_cap(input logic [15:0] e);
        rd_reg(`OFS_EV_STATUS, d);
        chk("capture", e, d & 16'h0001);
    endtask : chk_cap

    initial begin
        #200us;
        n_errors++;
        report_and_stop();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rd_reg(`OFS_MODE, d);
        chk("mode reset", `MODE_RESET, d);
        rd_reg(`OFS_IRQ_MASK, d);
        chk("mask reset", {8'h00, `MASK_RESET}, d);
        rd_reg(`OFS_IRQ_FLAGS, d);
        chk("flag reset", 16'h0000, d);
        chk("irq reset", 16'h0000, {15'h0000, irq});
        wr_reg(`OFS_MODE, 16'hffff);
        rd_reg(`OFS_MODE, d);
        chk("mode mask", `MODE_WMASK, d);
        wr_reg(4'hf, 16'hffff);
        rd_reg(4'hf, d);
        chk("unmapped", 16'h0000, d);
        wr_reg(`OFS_MODE, 16'h0004);
        wr_reg(`OFS_START, 16'h0000);
        settle(3);
        chk("start zero", 16'h0000, {15'h0000, en});
        wr_reg(`OFS_START, 16'h0001);
        settle(3);
        chk("start", 16'h0001, {15'h0000, en});
        wr_reg(`OFS_STOP, 16'h0000);
        settle(3);
        chk("stop zero", 16'h0001, {15'h0000, en});
        wr_reg(`OFS_STOP, 16'h0001);
        settle(3);
        chk("stop", 16'h0000, {15'h0000, en});
        // only the selected prescaler tick may advance the count
        for (int s = 0; s < 4; s++) begin
            prep({s[1:0], 14'h0004});
            rd_reg(`OFS_COUNT, c0);
            pulse(~(4'h1 << idx[s]));
            repeat (3) pulse(4'h1 << idx[s]);
            rd_reg(`OFS_COUNT, d);
            chk("clock select", 16'h0003, d - c0);
        end
        prep(16'h1004);
        rd_reg(`OFS_COUNT, c0);
        pin_to(1'b1);
        pin_to(1'b0);
        pin_to(1'b1);
        pin_to(1'b0);
        rd_reg(`OFS_COUNT, d);
        chk("pin count", 16'h0002, d - c0);
        prep(16'h0004);
        pin_to(1'b1);
        pin_to(1'b0);
        chk_cap(16'h0000);
        prep(16'h0104);
        pin_to(1'b1);
        pin_to(1'b0);
        pin_to(1'b1);
        chk_cap(16'h0000);
        pin_to(1'b0);
        chk_cap(16'h0001);
        rd_reg(`OFS_IRQ_FLAGS, d);
        chk("capture flag", 16'h0010, d & 16'h0010);
        prep(16'h02c4);
        pin_to(1'b1);
        chk_cap(16'h0000);
        pin_to(1'b0);
        chk_cap(16'h0001);
        prep(16'h0404);
        n_pulses = 0;
        mpulse();
        repeat (2) pulse(4'h1);
        mpulse();
        chk_cap(16'h0001);
        rd_reg(`OFS_DATA, d);
        chk("captured count", 16'h0002, d);
        chk("irq pulses", 16'h0001, 16'(n_pulses));
        wr_reg(`OFS_EV_ENABLE, 16'h0001);
        settle(2);
        chk("event irq", 16'h0001, {15'h0000, irq});
        wr_reg(`OFS_EV_CLEAR, 16'h0001);
        settle(2);
        chk("event clear", 16'h0000, {15'h0000, irq});
        // one-count: a second falling edge while counting reloads only in the restart variant
        wr_reg(`OFS_PERIOD, 16'h0003);
        for (int r = 0; r < 2; r++) begin
            prep(16'h0108 | 16'(r));
            pin_to(1'b1);
            pin_to(1'b0);
            pulse(4'h1);
            pin_to(1'b1);
            pin_to(1'b0);
            rd_reg(`OFS_COUNT, d);
            chk("one-count retrigger", (r == 1) ? 16'h0003 : 16'h0002, d);
        end
        for (int m = 0; m < 6; m++) begin
            prep(mds[m]);
            rd_reg(`OFS_IRQ_FLAGS, d);
            chk("start irq", fl[m], d & 16'h0010);
        end
        prep(16'h0005);
        chk("masked", 16'h0000, {15'h0000, irq});
        wr_reg(`OFS_IRQ_MASK, 16'h00ef);
        settle(2);
        chk("unmasked", 16'h0001, {15'h0000, irq});
        wr_reg(`OFS_IRQ_FLAGS, 16'h0000);
        settle(2);
        chk("flag clear", 16'h0000, {15'h0000, irq});
        report_and_stop();
    end
endmodule : tmr_chan_tb
`default_nettype wire
